/* pkg/gpsfm_pkg.sv */
/*
  Constants, register map, pin map and carrier types for the GPIO
  special-function pin multiplexer.
  Assumes a 32-bit APB3 slave port and 31 package pins numbered
  port0 bits 0-7, port1 bits 8-15, port2 bits 16-23, port6 bits 24-30.
*/
// How it works
// - Thirty-one GPIO pins, twenty with special functions
// - Enabled special function overrides port output/direction
// - GPIO control returns only after function disabled
// - Weak pull-up only while pin is input
// - DAC takes pin when config 01b or 10b
// - Reference B input when DAC 4-7 config 01b
// - PWM alternate pin needs enable, master, alternate
// - External clock pin active when any unit selects it
// - Seven registers per port, overridden by mux
package gpsfm_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_PINS = 31;
  localparam int NUM_PWM = 10; // PWM channels
  localparam int NUM_DAC = 8; // DAC channels
  localparam int NUM_ALT = 8; // PWM channels with an alternate pin
  localparam int ADDR_W = 12; // APB byte address width
  localparam logic [31:0] VALID_MASK = 32'h7fff_ffff; // Bit 31 has no pin
  localparam logic [31:0] RST_WORD = 32'h0000_0000; // Reset of all registers

  // ---------------------------------------------------------------
  // Register map: port block at index*0x20 (port6 at 0x60), word index inside block
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_OUT = 3'h0; // Port output
  localparam logic [2:0] REG_IN = 3'h1; // Port input, read only
  localparam logic [2:0] REG_DIR = 3'h2; // Port direction, 1 = output
  localparam logic [2:0] REG_EIF = 3'h3; // Edge flags, write 1 clears
  localparam logic [2:0] REG_EIE = 3'h4; // Edge flag enables
  localparam logic [2:0] REG_EIES = 3'h5; // Edge select, 1 = falling
  localparam logic [2:0] REG_PULLUP = 3'h6; // Weak pull-up select
  localparam logic [ADDR_W-1:0] ADDR_CFG_BASE = 12'h080; // First non-port word
  localparam logic [ADDR_W-1:0] ADDR_DAC_CFG = 12'h080; // 2 bits per DAC
  localparam logic [ADDR_W-1:0] ADDR_PWM_EN = 12'h084; // Channel enables
  localparam logic [ADDR_W-1:0] ADDR_PWM_ALT = 12'h088; // Alternate pin selects
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h08c; // Unit enables
  localparam logic [ADDR_W-1:0] ADDR_HELD = 12'h090; // Pins held, read only

  // Control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_PWM_MASTER = 0;
  localparam int CTRL_THREE_WIRE = 1;
  localparam int CTRL_I2C = 2;
  localparam int CTRL_SPI = 3;
  localparam int CTRL_TMR_EXTCLK = 4;
  localparam int CTRL_PWM_EXTCLK = 5;
  localparam int CTRL_SH_EXTCLK = 6;

  // DAC pin configuration codes
  localparam logic [1:0] DAC_CFG_EXT = 2'b01; // Pin plus external reference
  localparam logic [1:0] DAC_CFG_INT = 2'b10; // Pin, internal reference

  // ---------------------------------------------------------------
  // Pin indices of serial, reference and clock special pins
  // ---------------------------------------------------------------
  localparam int PIN_MDIO = 8; // Port1.0 serial data
  localparam int PIN_MCL = 9; // Port1.1 serial clock
  localparam int PIN_MCS = 10; // Port1.2 serial chip select
  localparam int PIN_MDI = 11; // Port1.3 SPI master data in
  localparam int PIN_REFB = 12; // Port1.4 reference input B
  localparam int PIN_REFA = 22; // Port2.6 reference input A
  localparam int PIN_EXT_CLK = 29; // Port6.5 external clock input

  // Default pin of PWM channel c, shared with DAC channel c
  function automatic int default_pin(input int c);
    case (c)
      0: default_pin = 4;
      1: default_pin = 5;
      2: default_pin = 29;
      3: default_pin = 13;
      4: default_pin = 14;
      5: default_pin = 15;
      6: default_pin = 30;
      7: default_pin = 23;
      8: default_pin = 6;
      default: default_pin = 7;
    endcase
  endfunction : default_pin

  // Alternate pin of PWM channel c, channels 0 to 7 only
  function automatic int alt_pin(input int c);
    case (c)
      0: alt_pin = 16;
      1: alt_pin = 17;
      2: alt_pin = 18;
      3: alt_pin = 19;
      4: alt_pin = 8;
      5: alt_pin = 11;
      6: alt_pin = 9;
      default: alt_pin = 10;
    endcase
  endfunction : alt_pin

  // Pin drive of one serial master: data, clock, chip select
  typedef struct packed {
    logic data_o; // Data level
    logic data_oe; // Data drive enable
    logic clk_o; // Clock level
    logic clk_oe; // Clock drive enable
    logic cs_o; // Chip select level
    logic cs_oe; // Chip select drive enable
  } gpsfm_serial_t;

endpackage : gpsfm_pkg

/* verilog/gpsfm_pin_mux.sv */
/*
  GPIO port registers on APB and the special-function pin multiplexer.
  Assumes the peripherals hand in their pin drive on pclk and read the
  filtered pin levels back; pins are split into level, drive, enable.
*/
`timescale 1ns/1ps
module gpsfm_pin_mux (
  input wire logic pclk, // Core clock, 25 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [gpsfm_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped word
  input wire logic [gpsfm_pkg::NUM_PINS-1:0] pin_in, // Pin levels
  output logic [gpsfm_pkg::NUM_PINS-1:0] pin_out, // Pin drive levels
  output logic [gpsfm_pkg::NUM_PINS-1:0] pin_oe, // Pin drive enables
  output logic [gpsfm_pkg::NUM_PINS-1:0] pin_pullup, // Weak pull-up enables
  input wire logic [gpsfm_pkg::NUM_PWM-1:0] pwm_out, // PWM channel outputs
  input wire gpsfm_pkg::gpsfm_serial_t three_wire_pins, // Three-wire drive
  input wire gpsfm_pkg::gpsfm_serial_t i2c_pins, // I2C master drive
  input wire gpsfm_pkg::gpsfm_serial_t spi_pins, // SPI master drive
  output logic [gpsfm_pkg::NUM_PINS-1:0] pin_level, // Filtered pin levels
  output logic [gpsfm_pkg::NUM_DAC-1:0] dac_pin_drive, // DAC owns its pin
  output logic ref_a_select, // Reference A pin in use
  output logic ref_b_select, // Reference B pin in use
  output logic ext_clock_active, // External clock pin in use
  output logic ext_clock_in // Filtered external clock level
);
  import gpsfm_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0] out_r, dir_r, eif_r, eie_r, eies_r, pu_r; // Port registers
  logic [15:0] dac_cfg_r; // DAC pin configuration fields
  logic [NUM_PWM-1:0] pwm_en_r; // PWM channel enables
  logic [NUM_PWM-1:0] pwm_alt_r; // PWM alternate pin selects
  logic [CTRL_W-1:0] ctrl_r; // Unit enables and clock selects
  logic [NUM_PINS-1:0] s1_r, s2_r, s3_r; // Input synchroniser stages
  logic [NUM_PINS-1:0] lvl_r; // Filtered pin level
  logic [31:0] prdata_r; // Read data
  logic pready_r, pslverr_r; // Access phase answer
  logic [NUM_PINS-1:0] pin_out_r, pin_oe_r, pin_pu_r; // Pin drive
  logic [NUM_DAC-1:0] dac_drive_r; // DAC ownership
  logic ref_a_r, ref_b_r, ext_act_r; // Analog and clock pin use

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte lane of one port inside the flat pin word
  function automatic logic [31:0] port_mask(input logic [1:0] p);
    port_mask = VALID_MASK & (32'h0000_00ff << {p, 3'b000});
  endfunction : port_mask

  // One port byte, right aligned
  function automatic logic [31:0] port_byte(input logic [31:0] v, input logic [1:0] p);
    port_byte = {24'h00_0000, v[{p, 3'b000} +: 8]};
  endfunction : port_byte

  // DAC pin taken for both configuration codes
  function automatic logic dac_drives(input logic [1:0] cfg);
    dac_drives = (cfg == DAC_CFG_EXT) || (cfg == DAC_CFG_INT);
  endfunction : dac_drives

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire [1:0] port_idx = paddr[6:5]; // Port 0, 1, 2, 6
  wire [2:0] reg_idx = paddr[4:2]; // Word inside port block
  wire port_blk = paddr < ADDR_CFG_BASE; // Port register block
  wire apb_setup = psel & ~penable; // Setup cycle
  wire apb_wr = psel & penable & pwrite & pready_r; // Write takes effect
  wire [31:0] port_m = port_mask(port_idx); // Addressed port lane
  wire [31:0] wr_byte = {4{pwdata[7:0]}} & port_m; // Data in that lane
  wire wr_port = apb_wr & port_blk; // Port block write
  wire wr_out = wr_port & (reg_idx == REG_OUT);
  wire wr_dir = wr_port & (reg_idx == REG_DIR);
  wire wr_eif = wr_port & (reg_idx == REG_EIF);
  wire wr_eie = wr_port & (reg_idx == REG_EIE);
  wire wr_eies = wr_port & (reg_idx == REG_EIES);
  wire wr_pu = wr_port & (reg_idx == REG_PULLUP);
  wire wr_dac = apb_wr & (paddr == ADDR_DAC_CFG);
  wire wr_pen = apb_wr & (paddr == ADDR_PWM_EN);
  wire wr_palt = apb_wr & (paddr == ADDR_PWM_ALT);
  wire wr_ctrl = apb_wr & (paddr == ADDR_CTRL);

  logic [NUM_PINS-1:0] sp_sel, sp_out, sp_oe; // Special function claim

  // Read mux; unmapped words read zero with an error
  logic [31:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_val = RST_WORD;
    rd_hit = 1'b1;
    if (port_blk) begin
      if (reg_idx == REG_OUT) rd_val = port_byte(out_r, port_idx);
      else if (reg_idx == REG_IN) rd_val = port_byte({1'b0, lvl_r}, port_idx);
      else if (reg_idx == REG_DIR) rd_val = port_byte(dir_r, port_idx);
      else if (reg_idx == REG_EIF) rd_val = port_byte(eif_r, port_idx);
      else if (reg_idx == REG_EIE) rd_val = port_byte(eie_r, port_idx);
      else if (reg_idx == REG_EIES) rd_val = port_byte(eies_r, port_idx);
      else if (reg_idx == REG_PULLUP) rd_val = port_byte(pu_r, port_idx);
      else rd_hit = 1'b0;
    end else if (paddr == ADDR_DAC_CFG) rd_val = {16'h0000, dac_cfg_r};
    else if (paddr == ADDR_PWM_EN) rd_val = {22'h0, pwm_en_r};
    else if (paddr == ADDR_PWM_ALT) rd_val = {22'h0, pwm_alt_r};
    else if (paddr == ADDR_CTRL) rd_val = {25'h0, ctrl_r};
    else if (paddr == ADDR_HELD) rd_val = {1'b0, sp_sel};
    else rd_hit = 1'b0;
  end

  // ---------------------------------------------------------------
  // Input filter and edge flags
  // ---------------------------------------------------------------
  // Take the new level only where stages two and three agree
  wire [NUM_PINS-1:0] lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
  wire [NUM_PINS-1:0] rise = lvl_nxt & ~lvl_r;
  wire [NUM_PINS-1:0] fall = ~lvl_nxt & lvl_r;
  wire [NUM_PINS-1:0] eif_set = (rise & ~eies_r[NUM_PINS-1:0]) | (fall & eies_r[NUM_PINS-1:0]);
  // Set wins over a clear written in the same cycle
  wire [31:0] eif_clr = wr_eif ? wr_byte : RST_WORD;
  wire [31:0] eif_nxt = ((eif_r & ~eif_clr) | {1'b0, eif_set}) & VALID_MASK;

  // ---------------------------------------------------------------
  // Function enables
  // ---------------------------------------------------------------
  wire master_en = ctrl_r[CTRL_PWM_MASTER];
  logic [NUM_PWM-1:0] pwm_def, pwm_alt; // PWM on default or alternate pin
  logic [NUM_DAC-1:0] dac_on, dac_ext; // DAC owns pin, external reference
  for (genvar c = 0; c < NUM_PWM; c++) begin : g_pwm
    assign pwm_def[c] = pwm_en_r[c] & master_en & ~pwm_alt_r[c];
    assign pwm_alt[c] = pwm_en_r[c] & master_en & pwm_alt_r[c];
  end
  for (genvar c = 0; c < NUM_DAC; c++) begin : g_dac
    assign dac_on[c] = dac_drives(dac_cfg_r[2*c +: 2]);
    assign dac_ext[c] = dac_cfg_r[2*c +: 2] == DAC_CFG_EXT;
  end
  wire refa_any = |dac_ext[3:0];
  wire refb_any = |dac_ext[7:4];
  wire ext_clk_any = ctrl_r[CTRL_TMR_EXTCLK] | ctrl_r[CTRL_PWM_EXTCLK]
                   | ctrl_r[CTRL_SH_EXTCLK];

  // ---------------------------------------------------------------
  // Pin claim; later assignments take precedence
  // ---------------------------------------------------------------
  always_comb begin
    sp_sel = '0;
    sp_out = '0;
    sp_oe = '0;
    // Clock input sits below DAC and PWM on its shared pin
    if (ext_clk_any) sp_sel[PIN_EXT_CLK] = 1'b1;
    for (int c = 0; c < NUM_PWM; c++) begin
      if (pwm_def[c]) begin
        sp_sel[default_pin(c)] = 1'b1;
        sp_out[default_pin(c)] = pwm_out[c];
        sp_oe[default_pin(c)] = 1'b1;
      end
    end
    // Analog use floats the digital driver
    for (int c = 0; c < NUM_DAC; c++) begin
      if (dac_on[c]) begin
        sp_sel[default_pin(c)] = 1'b1;
        sp_out[default_pin(c)] = 1'b0;
        sp_oe[default_pin(c)] = 1'b0;
      end
    end
    if (refa_any) sp_sel[PIN_REFA] = 1'b1;
    if (refb_any) sp_sel[PIN_REFB] = 1'b1;
    for (int c = 0; c < NUM_ALT; c++) begin
      if (pwm_alt[c]) begin
        sp_sel[alt_pin(c)] = 1'b1;
        sp_out[alt_pin(c)] = pwm_out[c];
        sp_oe[alt_pin(c)] = 1'b1;
      end
    end
    if (ctrl_r[CTRL_SPI]) begin
      sp_sel[PIN_MDIO] = 1'b1;
      sp_out[PIN_MDIO] = spi_pins.data_o;
      sp_oe[PIN_MDIO] = spi_pins.data_oe;
      sp_sel[PIN_MCL] = 1'b1;
      sp_out[PIN_MCL] = spi_pins.clk_o;
      sp_oe[PIN_MCL] = spi_pins.clk_oe;
      sp_sel[PIN_MCS] = 1'b1;
      sp_out[PIN_MCS] = spi_pins.cs_o;
      sp_oe[PIN_MCS] = spi_pins.cs_oe;
      sp_sel[PIN_MDI] = 1'b1;
      sp_out[PIN_MDI] = 1'b0;
      sp_oe[PIN_MDI] = 1'b0;
    end
    if (ctrl_r[CTRL_I2C]) begin
      sp_sel[PIN_MDIO] = 1'b1;
      sp_out[PIN_MDIO] = i2c_pins.data_o;
      sp_oe[PIN_MDIO] = i2c_pins.data_oe;
      sp_sel[PIN_MCL] = 1'b1;
      sp_out[PIN_MCL] = i2c_pins.clk_o;
      sp_oe[PIN_MCL] = i2c_pins.clk_oe;
    end
    if (ctrl_r[CTRL_THREE_WIRE]) begin
      sp_sel[PIN_MDIO] = 1'b1;
      sp_out[PIN_MDIO] = three_wire_pins.data_o;
      sp_oe[PIN_MDIO] = three_wire_pins.data_oe;
      sp_sel[PIN_MCL] = 1'b1;
      sp_out[PIN_MCL] = three_wire_pins.clk_o;
      sp_oe[PIN_MCL] = three_wire_pins.clk_oe;
      sp_sel[PIN_MCS] = 1'b1;
      sp_out[PIN_MCS] = three_wire_pins.cs_o;
      sp_oe[PIN_MCS] = three_wire_pins.cs_oe;
    end
  end

  // Port registers apply only where no function holds the pin
  wire [NUM_PINS-1:0] gpio_dir = dir_r[NUM_PINS-1:0];
  wire [NUM_PINS-1:0] out_nxt_pin = (sp_sel & sp_out) | (~sp_sel & out_r[NUM_PINS-1:0]);
  wire [NUM_PINS-1:0] oe_nxt_pin = (sp_sel & sp_oe) | (~sp_sel & gpio_dir);
  wire [NUM_PINS-1:0] pu_nxt_pin = pu_r[NUM_PINS-1:0] & ~gpio_dir & ~sp_sel;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Software-visible state; byte writes only touch the addressed port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= RST_WORD;
      dir_r <= RST_WORD;
      eif_r <= RST_WORD;
      eie_r <= RST_WORD;
      eies_r <= RST_WORD;
      pu_r <= RST_WORD;
      dac_cfg_r <= '0;
      pwm_en_r <= '0;
      pwm_alt_r <= '0;
      ctrl_r <= '0;
    end else begin
      if (wr_out) out_r <= (out_r & ~port_m) | wr_byte;
      if (wr_dir) dir_r <= (dir_r & ~port_m) | wr_byte;
      if (wr_eie) eie_r <= (eie_r & ~port_m) | wr_byte;
      if (wr_eies) eies_r <= (eies_r & ~port_m) | wr_byte;
      if (wr_pu) pu_r <= (pu_r & ~port_m) | wr_byte;
      eif_r <= eif_nxt;
      if (wr_dac) dac_cfg_r <= pwdata[15:0];
      if (wr_pen) pwm_en_r <= pwdata[NUM_PWM-1:0];
      if (wr_palt) pwm_alt_r <= pwdata[NUM_PWM-1:0];
      if (wr_ctrl) ctrl_r <= pwdata[CTRL_W-1:0];
    end
  end

  // Three-stage input chain; stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // Answer is prepared in setup so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= RST_WORD;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_setup;
      pslverr_r <= apb_setup & ~rd_hit;
      if (apb_setup) prdata_r <= pwrite ? RST_WORD : rd_val;
    end
  end

  // Pin drive registered, one cycle behind the claim
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
      pin_pu_r <= '0;
      dac_drive_r <= '0;
      ref_a_r <= 1'b0;
      ref_b_r <= 1'b0;
      ext_act_r <= 1'b0;
    end else begin
      pin_out_r <= out_nxt_pin;
      pin_oe_r <= oe_nxt_pin;
      pin_pu_r <= pu_nxt_pin;
      dac_drive_r <= dac_on;
      ref_a_r <= refa_any;
      ref_b_r <= refb_any;
      ext_act_r <= ext_clk_any;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign pin_pullup = pin_pu_r;
  assign pin_level = lvl_r;
  assign dac_pin_drive = dac_drive_r;
  assign ref_a_select = ref_a_r;
  assign ref_b_select = ref_b_r;
  assign ext_clock_active = ext_act_r;
  assign ext_clock_in = lvl_r[PIN_EXT_CLK];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  gpio_follow_a: assert property (
    ##1 ((pin_out_r ^ $past(out_r[NUM_PINS-1:0])) & ~$past(sp_sel)) == '0)
    else $error("free pin does not follow port output");
  special_wins_a: assert property (
    ##1 ((pin_out_r ^ $past(sp_out)) & $past(sp_sel)) == '0)
    else $error("held pin does not carry function output");
  gpio_lost_a: assert property (
    ##1 ((pin_oe_r ^ $past(sp_oe)) & $past(sp_sel)) == '0)
    else $error("port direction leaks onto held pin");
  pullup_input_a: assert property (
    ##1 (pin_pu_r & ($past(gpio_dir) | $past(sp_sel))) == '0)
    else $error("pull-up on output or held pin");
  dac_pin_a: assert property (
    (dac_cfg_r[1:0] == DAC_CFG_INT) |=> (dac_pin_drive[0] && !pin_oe[4]))
    else $error("DAC0 pin not taken");
  refb_pin_a: assert property (
    $rose(dac_ext[4])
      |=> ref_b_select ##1 (ref_b_select == $past(refb_any)))
    else $error("reference B select wrong");
  pwm_alt_a: assert property (
    (pwm_en_r[0] && master_en && pwm_alt_r[0]) |=> (pin_oe[16] && pin_out[16] == $past(pwm_out[0])))
    else $error("PWM0 alternate pin not driven");
  ext_clk_a: assert property (
    ##1 (ext_clock_active == $past(ext_clk_any)))
    else $error("external clock pin not activated");
  edge_flag_a: assert property (
    (rise[0] && !eies_r[0]) |=> eif_r[0])
    else $error("rising edge flag lost");
  serial_prio_a: assert property (
    (ctrl_r[CTRL_THREE_WIRE] && ctrl_r[CTRL_I2C])
      |=> pin_out[PIN_MDIO] == $past(three_wire_pins.data_o))
    else $error("three-wire does not win data pin");

endmodule : gpsfm_pin_mux

/* verif/gpsfm_periph_model.sv */
/*
  Peripheral-side model: serial masters, PWM outputs and the pad wires.
  Assumes the mux drives the pads through pin_out, pin_oe and pin_pullup.
*/
`timescale 1ns/1ps
module gpsfm_periph_model (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Reset, active low
  input wire logic [gpsfm_pkg::NUM_PINS-1:0] pin_out, // Pad drive levels
  input wire logic [gpsfm_pkg::NUM_PINS-1:0] pin_oe, // Pad drive enables
  input wire logic [gpsfm_pkg::NUM_PINS-1:0] pin_pullup, // Pull-up enables
  output logic [gpsfm_pkg::NUM_PWM-1:0] pwm_out, // PWM levels
  output gpsfm_pkg::gpsfm_serial_t three_wire_pins, // Three-wire drive
  output gpsfm_pkg::gpsfm_serial_t i2c_pins, // I2C drive
  output gpsfm_pkg::gpsfm_serial_t spi_pins, // SPI drive
  output logic [gpsfm_pkg::NUM_PINS-1:0] pin_in // Pad levels
);
  import gpsfm_pkg::*;
  // ---------------------------------------------------------------
  // Masters
  // ---------------------------------------------------------------
  logic float_r; // Toggles so a floating pad never looks settled
  // Distinct fixed drive per master, so pad ownership is visible
  assign pwm_out = '0;
  assign three_wire_pins = 6'b110111; // Data 1, clock 0, all driven
  assign i2c_pins = 6'b000100; // Open drain: data released, clock low
  assign spi_pins = 6'b111111; // Data 1, clock 1, all driven
  // ---------------------------------------------------------------
  // Pads
  // ---------------------------------------------------------------
  // A released pad without pull-up shows a changing level, not the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      float_r <= 1'b0;
    end else begin
      float_r <= ~float_r;
    end
  end
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pad
    assign pin_in[i] = pin_oe[i] ? pin_out[i] : (pin_pullup[i] | float_r);
  end
endmodule : gpsfm_periph_model

/* verif/test_gpio_special_function_pin_mux.sv */
/*
  Self-checking bench for the pin multiplexer, driven as an APB master.
  Assumes the peripheral model sits on the pads and master drive inputs.
*/
`timescale 1ns/1ps
module test_gpio_special_function_pin_mux;
  import gpsfm_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic pclk = 1'b0; // Core clock, 40 ns
  logic presetn = 1'b0; // Reset, active low
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB access phase
  logic pwrite = 1'b0; // APB direction
  logic [ADDR_W-1:0] paddr = '0; // APB address
  logic [31:0] pwdata = '0; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready, pslverr; // APB answer
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, pin_pullup, pin_level; // Pads
  logic [NUM_PWM-1:0] pwm_out; // PWM levels
  gpsfm_serial_t three_wire_pins, i2c_pins, spi_pins; // Master drive
  logic [NUM_DAC-1:0] dac_pin_drive; // DAC ownership
  logic ref_a_select, ref_b_select, ext_clock_active, ext_clock_in; // Status
  int miscompares = 0; // Mismatches seen
  int checked = 0; // Comparisons made
  // Owner signature of pads 9:8: enables then levels
  wire logic [3:0] pin_sig = {pin_oe[9:8], pin_out[9:8]};
  logic [6:0] ctrl_tab [4] = '{7'h0f, 7'h0d, 7'h09, 7'h01}; // Units on
  logic [3:0] sig_tab [4] = '{4'b1101, 4'b1000, 4'b1111, 4'b1100}; // Owner
  always #20 pclk = ~pclk;
  gpsfm_pin_mux gpsfm_pin_mux_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pwm_out(pwm_out),
    .three_wire_pins(three_wire_pins), .i2c_pins(i2c_pins), .spi_pins(spi_pins),
    .pin_level(pin_level), .dac_pin_drive(dac_pin_drive), .ref_a_select(ref_a_select),
    .ref_b_select(ref_b_select), .ext_clock_active(ext_clock_active),
    .ext_clock_in(ext_clock_in));
  gpsfm_periph_model gpsfm_periph_model_inst (.pclk(pclk), .presetn(presetn),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pwm_out(pwm_out),
    .three_wire_pins(three_wire_pins), .i2c_pins(i2c_pins), .spi_pins(spi_pins),
    .pin_in(pin_in));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("FAIL %0t no ready", $time);
      conclude();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    repeat (3) @(posedge pclk); // Register, then pads, then settled
  endtask : wr
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, ee});
  endtask : rd_chk
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h020, RST_WORD, 1'b0);
    wr(12'h020, 32'h02); // Port1 out: pad 9 high, pad 8 low
    wr(12'h028, 32'hff);
    check(pin_sig, 4'b1110);
    wr(ADDR_PWM_EN, 32'h51); // Channels 0, 4, 6; master still off
    check({pin_oe[16], pin_oe[4]}, 2'b00);
    wr(ADDR_CTRL, 32'h01);
    check({pin_oe[16], pin_oe[4]}, 2'b01);
    wr(ADDR_PWM_ALT, 32'h51);
    check({pin_oe[16], pin_oe[4]}, 2'b10);
    // Peel off owners one at a time, highest first
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, {25'h0, ctrl_tab[i]});
      check(pin_sig, sig_tab[i]);
    end
    wr(ADDR_PWM_EN, 32'h0);
    check(pin_sig, 4'b1110);
    wr(ADDR_CTRL, 32'h0);
    // Every DAC code on channel 5, which also feeds reference B
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_DAC_CFG, (c << 10) | c); // Channels 0 and 5 alike
      check(dac_pin_drive[5], c == 1 || c == 2);
      check(ref_a_select, c == 1);
      check(ref_b_select, c == 1);
    end
    for (int b = CTRL_TMR_EXTCLK; b <= CTRL_SH_EXTCLK; b++) begin
      wr(ADDR_CTRL, 1 << b);
      check(ext_clock_active, 1'b1);
    end
    rd_chk(ADDR_HELD, 32'h2000_0000, 1'b0);
    wr(ADDR_CTRL, 32'h0);
    check(ext_clock_active, 1'b0);
    wr(12'h060, 32'h20); // Port6 drives pad 29 high as plain GPIO
    wr(12'h068, 32'h20);
    wr(12'h058, 32'h01); // Port2 pull-up on pad 16, pad is input
    check(pin_pullup[16], 1'b1);
    wr(12'h048, 32'h01);
    check(pin_pullup[16], 1'b0);
    repeat (4) @(posedge pclk); // Input filter settles
    check(ext_clock_in, 1'b1);
    check(pin_level[15:8], 8'h02);
    rd_chk(12'h024, 32'h02, 1'b0);
    wr(12'h024, 32'hff); // Input register is read only
    rd_chk(12'h024, 32'h02, 1'b0);
    rd_chk(12'h0a0, 32'h0, 1'b1);
    rd_chk(12'h028, 32'hff, 1'b0);
    // Drive pad 0 high to raise its rising edge flag, then clear it
    wr(12'h000, 32'h01);
    wr(12'h008, 32'h01);
    repeat (4) @(posedge pclk); // Input filter settles
    rd_chk(12'h00c, 32'h01, 1'b0);
    wr(12'h00c, 32'h01);
    rd_chk(12'h00c, 32'h00, 1'b0);
    conclude();
  end
endmodule : test_gpio_special_function_pin_mux
